/* dv/hub_link_sva.sv */
// checker on the serial link wires between host end and hub target
// assumes it is instantiated beside the link interface
`timescale 1ns/1ps
module hub_link_sva (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic host_scl_o,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_dev_level_low: assert property (dev_sda_o == 1'b0) else $error("target level");
    a_host_level_low: assert property (!host_scl_o && !host_sda_o) else $error("host level");
    a_dev_grab_low: assert property ($fell(dev_sda_oe) |-> !scl) else $error("target took data high");
    a_dev_free_low: assert property ($rose(dev_sda_oe) |-> !scl) else $error("target freed data high");
    a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("target moved");
    a_edge_by_host: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
        else $error("edge not by host");
    a_scl_high_min: assert property ($rose(scl) |-> scl[*4]) else $error("clock high short");
    a_idle_release: assert property ($fell(rst_i) |-> scl && sda) else $error("lines held");
endmodule // hub_link_sva

/* dv/test_hub_i2c_target_packet_logic.sv */
// bench: host end and hub target facing each other over the link interface
// assumes the host end divides the reference clock to make the serial clock
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h seen %h", n, e, s); end end
module test_hub_i2c_target_packet_logic import hub_pkg::*; ;
    localparam int Q = 8;
    int         miscompares = 0;
    int         n_compared = 0;
    logic       ref_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_last_i = 1'b0;
    logic       two_b = 1'b0, dptr_en = 1'b0, refuse = 1'b0, ill_seen = 1'b0;
    logic [2:0] page = 3'h0;
    logic [7:0] cmd_data_i = 8'h00;
    hub_cmd_t   cmd_i = CMD_STOP;
    logic       cmd_ready_o, done_o, ack_o, ill_o;
    logic [7:0] rd_data_o, local_data_o;
    logic [6:0] local_addr_o;
    logic       lrw_o, lst_o, ldv_o, lrq_o, lsp_o;
    logic [3:0] lseen = 4'h0;
    logic [2:0] host_side_module_id = 3'h0;
    hub_link_if link ();
    always #2.5 ref_clk_i = ~ref_clk_i;
    // illegal flag is a one-cycle pulse, so keep it until looked at
    always @(posedge ref_clk_i) if (ill_o === 1'b1) ill_seen <= 1'b1;
    // local pulses kept sticky the same way: start, data valid, read request, stop
    always @(posedge ref_clk_i) if (!rst_i) lseen <= lseen | {lst_o, ldv_o, lrq_o, lsp_o};
    hub_host #(.QTR_CYC(Q)) hub_host_inst (.ref_clk_i, .rst_i, .link(link), .cmd_valid_i, .cmd_i, .cmd_data_i,
        .cmd_last_i, .cmd_ready_o, .done_o, .rd_data_o, .ack_o);
    hub_target hub_target_inst (.ref_clk_i, .rst_i, .link(link), .host_side_module_id_i(host_side_module_id),
        .two_byte_addressing_select_i(two_b), .page_pointer_field_i(page), .default_pointer_enable_i(dptr_en),
        .default_pointer_start_select_i(2'h1), .refuse_read_i(refuse), .local_rd_data_i(8'h96), .local_addr_o,
        .local_rw_o(lrw_o), .local_start_o(lst_o), .local_data_o, .local_data_valid_o(ldv_o),
        .local_rd_req_o(lrq_o), .local_stop_o(lsp_o),
        .illegal_op_o(ill_o));
    hub_link_sva hub_link_sva_inst (.ref_clk_i, .rst_i, .host_scl_o(link.host_scl_o), .host_sda_o(link.host_sda_o),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl),
        .sda(link.sda));
    task op(input hub_cmd_t c, input logic [7:0] d, input logic l);
        for (int n = 0; n < 2000 && cmd_ready_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
        cmd_i = c;
        {cmd_data_i, cmd_last_i, cmd_valid_i} = {d, l, 1'b1};
        @(posedge ref_clk_i) #1;
        cmd_valid_i = 1'b0;
        for (int n = 0; n < 2000 && done_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
    endtask
    task wb(input logic [7:0] d, input logic a);
        op(CMD_WRITE, d, 1'b0);
        `CHK("ack", a, ack_o)
    endtask
    task rb(input logic l, input logic [7:0] e);
        op(CMD_READ, 8'h00, l);
        `CHK("read", e, rd_data_o)
    endtask
    task s(); op(CMD_START, 8'h00, 1'b0); endtask
    task p(); op(CMD_STOP, 8'h00, 1'b0); endtask
    task hdr(input logic [7:0] b);
        s();
        wb(8'hA0, 1'b1);
        wb(b, 1'b1);
    endtask
    task t_array();
        two_b = 1'b1;
        hdr(8'h81);
        wb(8'h09, 1'b1);
        wb(8'hA5, 1'b1);
        wb(8'h5A, 1'b1);
        p();
        two_b = 1'b0;
        page = 3'h1;
        hdr(8'h81);
        s();
        wb(8'hA1, 1'b1);
        rb(1'b0, 8'hA5);
        rb(1'b1, 8'h5A);
        p();
    endtask
    task t_dptr();
        dptr_en = 1'b1;
        hdr(8'h10);
        wb(8'h77, 1'b1);
        p();
        refuse = 1'b1;
        s();
        wb(8'hA1, 1'b0);
        refuse = 1'b0;
        s();
        wb(8'hA1, 1'b1);
        rb(1'b1, 8'h77);
        p();
    endtask
    task t_local();
        s();
        wb(8'hB0, 1'b1);
        `CHK("laddr", 7'h5F, local_addr_o)
        wb(8'hE1, 1'b1);
        `CHK("ldata", 8'hE1, local_data_o)
        `CHK("lstart", 1'b1, lseen[3])
        `CHK("lvalid", 1'b1, lseen[2])
        p();
        `CHK("lstop", 1'b1, lseen[0])
        s();
        wb(8'hB1, 1'b1);
        `CHK("lrw", 1'b1, lrw_o)
        rb(1'b1, 8'h96);
        `CHK("lrdreq", 1'b1, lseen[1])
        p();
        s();
        wb(8'hA2, 1'b0);
        s();
        op(CMD_WRITE, 8'hFC, 1'b0);
        s();
        wb(8'hA0, 1'b0);
        `CHK("illegal", 1'b1, ill_seen)
        p();
    endtask
    task wrap_up();
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        t_array();
        t_dptr();
        t_local();
        wrap_up();
    end
    // some 41 commands of up to about 300 cycles each; allow several times that
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule // test_hub_i2c_target_packet_logic

/* hw/hub_host.sv */
// host end: makes the serial clock by division and runs start, stop and byte commands
// assumes the target never stretches the clock
`timescale 1ns/1ps

module hub_host import hub_pkg::*; #(
    parameter int QTR_CYC = SCL_QTR_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    hub_link_if.host        link,
    input  wire logic       cmd_valid_i,
    input  wire hub_cmd_t   cmd_i,
    input  wire logic [7:0] cmd_data_i,
    input  wire logic       cmd_last_i,
    output logic            cmd_ready_o,
    output logic            done_o,
    output logic [7:0]      rd_data_o,
    output logic            ack_o
);

    // ====================================================================
    // data line synchroniser
    logic [2:0] sda_s;
    logic       sda_f;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_s <= SYNC_RESET;
            sda_f <= 1'b1;
        end else begin
            sda_s <= {sda_s[1:0], link.sda};
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
        end
    end

    // ====================================================================
    // quarter-period sequencer
    hub_hst_t   st;
    logic [15:0] qcnt;
    logic [5:0]  step;
    logic [7:0]  tx;
    logic        rd;
    logic        last;
    logic [7:0]  rx;
    wire  [3:0]  bitn = step[5:2];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st               <= H_IDLE;
            qcnt             <= 16'h0000;
            step             <= 6'h00;
            tx               <= 8'h00;
            rd               <= 1'b0;
            last             <= 1'b0;
            rx               <= 8'h00;
            cmd_ready_o      <= 1'b1;
            done_o           <= 1'b0;
            rd_data_o        <= 8'h00;
            ack_o            <= 1'b0;
            link.host_scl_o  <= 1'b0;
            link.host_scl_oe <= 1'b1;
            link.host_sda_o  <= 1'b0;
            link.host_sda_oe <= 1'b1;
        end else begin
            done_o <= 1'b0;
            if (st == H_IDLE) begin
                if (cmd_valid_i) begin
                    cmd_ready_o <= 1'b0;
                    step        <= 6'h00;
                    qcnt        <= 16'h0000;
                    tx          <= cmd_data_i;
                    rd          <= (cmd_i == CMD_READ);
                    last        <= cmd_last_i;
                    case (cmd_i)
                        CMD_START: st <= H_START;
                        CMD_STOP:  st <= H_STOP;
                        default:   st <= H_BYTE;
                    endcase
                end
            end else if (qcnt != 16'h0000) begin
                qcnt <= qcnt - 16'h0001;
            end else begin
                qcnt <= 16'(QTR_CYC - 1);
                step <= step + 6'h01;
                case (st)
                    // R16 start or repeated start
                    H_START: begin
                        case (step)
                            6'h00:   link.host_sda_oe <= 1'b1;
                            6'h01:   link.host_scl_oe <= 1'b1;
                            6'h02:   link.host_sda_oe <= 1'b0;
                            6'h03:   link.host_scl_oe <= 1'b0;
                            default: st <= H_IDLE;
                        endcase
                    end
                    H_STOP: begin
                        case (step)
                            6'h00:   link.host_sda_oe <= 1'b0;
                            6'h01:   link.host_scl_oe <= 1'b1;
                            6'h02:   link.host_sda_oe <= 1'b1;
                            default: st <= H_IDLE;
                        endcase
                    end
                    H_BYTE: begin
                        if (bitn == 4'h9) begin
                            st        <= H_IDLE;
                            rd_data_o <= rx;
                        end else begin
                            case (step[1:0])
                                2'h0: begin
                                    if (bitn == 4'h8) begin
                                        // R20 last read byte refused
                                        link.host_sda_oe <= !rd || last;
                                    end else begin
                                        link.host_sda_oe <= rd || tx[3'(4'h7 - bitn)];
                                    end
                                end
                                2'h1: link.host_scl_oe <= 1'b1;
                                2'h2: begin
                                    if (bitn == 4'h8) begin
                                        // R07 not-acknowledge reported for retry
                                        ack_o <= !sda_f;
                                    end else begin
                                        rx <= {rx[6:0], sda_f};
                                    end
                                end
                                default: link.host_scl_oe <= 1'b0;
                            endcase
                        end
                    end
                    default: st <= H_IDLE;
                endcase
                if ((st == H_START && step == 6'h04) || (st == H_STOP && step == 6'h03) ||
                    (st == H_BYTE && bitn == 4'h9)) begin
                    done_o      <= 1'b1;
                    cmd_ready_o <= 1'b1;
                end
            end
        end
    end

endmodule // hub_host

/* hw/hub_link_if.sv */
// open-drain host serial clock and data lines between host end and hub target
// assumes released lines are pulled high; enables are low while driving
`timescale 1ns/1ps
interface hub_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up
    assign scl = host_scl_oe | host_scl_o;
    assign sda = (host_sda_oe | host_sda_o) & (dev_sda_oe | dev_sda_o);

    modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

/* hw/hub_pkg.sv */
// shared constants and types of the hub two-wire target logic and its host end
// assumes both ends run on the same 200 MHz reference clock
package hub_pkg;

    // ====================================================================
    // addressing
    localparam logic [3:0] HUB_LID        = 4'hA;
    localparam logic [6:0] BCAST_ADDR     = 7'h7E;
    localparam logic [2:0] LOCAL_SUB_ID   = 3'h7;
    localparam int         NVM_AW         = 10;
    localparam int         REG_AW         = 7;
    localparam int         NVM_BYTES      = 1024;
    localparam int         REG_BYTES      = 128;
    localparam logic [1:0] IDX_ADDR       = 2'h0;
    localparam logic [1:0] IDX_FIRST      = 2'h1;
    localparam logic [1:0] IDX_SECOND     = 2'h2;
    localparam logic [1:0] IDX_DATA       = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // ====================================================================
    // default read pointer start addresses, one per select code
    localparam logic [6:0] DEF_PTR_0      = 7'h00;
    localparam logic [6:0] DEF_PTR_1      = 7'h10;
    localparam logic [6:0] DEF_PTR_2      = 7'h20;
    localparam logic [6:0] DEF_PTR_3      = 7'h30;

    // ====================================================================
    // timing
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         SCL_PERIOD_NS  = 1000;
    localparam int         SCL_QTR_CYC    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [2:0] SYNC_RESET     = 3'h7;

    // ====================================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK  = 3'b010,
        ST_SEND = 3'b011,
        ST_RACK = 3'b100
    } hub_dev_st_t;

    typedef enum logic [1:0] {
        K_NONE  = 2'b00,
        K_SELF  = 2'b01,
        K_LOCAL = 2'b10,
        K_BCAST = 2'b11
    } hub_kind_t;

    typedef enum logic [1:0] {
        CMD_START = 2'b00,
        CMD_STOP  = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_READ  = 2'b11
    } hub_cmd_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_START = 2'b01,
        H_STOP  = 2'b10,
        H_BYTE  = 2'b11
    } hub_hst_t;

    function automatic logic [6:0] hub_def_ptr(input logic [1:0] sel);
        case (sel)
            2'h0:    hub_def_ptr = DEF_PTR_0;
            2'h1:    hub_def_ptr = DEF_PTR_1;
            2'h2:    hub_def_ptr = DEF_PTR_2;
            default: hub_def_ptr = DEF_PTR_3;
        endcase
    endfunction

endpackage

/* hw/hub_target.sv */
// hub target packet logic: parses host packets, holds array and register space,
// forwards local-device packets. assumes the host only drives data while clock is low
`timescale 1ns/1ps

// How it works
// R01 - address bit 7 picks array or registers
// R02 - register access ignores block meaning
// R03 - write: address, offset byte, acked data
// R04 - read: set address, repeated start, stream
// R05 - second address byte carries block bits
// R06 - block address bit 4 ignored
// R07 - repeated-start read may be refused
// R08 - broadcast only for commands, else illegal
// R09 - stop reloads pointer in default mode
// R10 - enable and start select control pins
// R11 - default mode read needs address only
// R12 - default pointer only for register space
// R13 - host should enable default mode
// R14 - local packets forwarded as plain data
// R15 - check bytes forwarded unchecked
// R16 - start, 7-bit address, direction, acknowledge
// R17 - local code kept, own id substituted
// R18 - two-byte mode reaches whole array
// R19 - page field picks 128-byte page
// R20 - host ends read with not-acknowledge
// R21 - pointer advances after every data byte
module hub_target import hub_pkg::*; #(
    parameter logic [2:0] LOCAL_ID = LOCAL_SUB_ID
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    hub_link_if.device      link,
    input  wire logic [2:0] host_side_module_id_i,
    input  wire logic       two_byte_addressing_select_i,
    input  wire logic [2:0] page_pointer_field_i,
    input  wire logic       default_pointer_enable_i,
    input  wire logic [1:0] default_pointer_start_select_i,
    input  wire logic       refuse_read_i,
    input  wire logic [7:0] local_rd_data_i,
    output logic [6:0]      local_addr_o,
    output logic            local_rw_o,
    output logic            local_start_o,
    output logic [7:0]      local_data_o,
    output logic            local_data_valid_o,
    output logic            local_rd_req_o,
    output logic            local_stop_o,
    output logic            illegal_op_o
);

    // ====================================================================
    // line synchronisers and edge finding
    logic [2:0]     scl_s;
    logic [2:0]     sda_s;
    logic           scl_f;
    logic           sda_f;
    logic           scl_p;
    logic           sda_p;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s <= SYNC_RESET;
            sda_s <= SYNC_RESET;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], link.scl};
            sda_s <= {sda_s[1:0], link.sda};
            if (scl_s[1] == scl_s[2]) begin
                scl_f <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // R16 start and stop
    wire scl_rise  = scl_f & ~scl_p;
    wire scl_fall  = ~scl_f & scl_p;
    wire start_det = scl_f & scl_p & sda_p & ~sda_f;
    wire stop_det  = scl_f & scl_p & ~sda_p & sda_f;

    // ====================================================================
    // storage
    logic [7:0]        nvm_mem [NVM_BYTES];
    logic [7:0]        reg_mem [REG_BYTES];
    hub_dev_st_t       st;
    hub_kind_t         kind;
    hub_kind_t         next_kind;
    logic [3:0]        bit_cnt;
    logic [1:0]        byte_idx;
    logic [7:0]        rx_sh;
    logic [7:0]        tx_sh;
    logic              rw;
    logic              tgt_nvm;
    logic              bcast_seen;
    logic              sda_oe;
    logic [NVM_AW-1:0] ptr;
    logic              next_ack;
    logic              next_ill;
    logic              is_data;
    logic [7:0]        next_tx;

    wire byte_done = (st == ST_RECV) && scl_fall && (bit_cnt == BITS_PER_BYTE);
    wire load_now  = scl_fall && (((st == ST_ACK) && rw && !sda_oe) || (st == ST_RACK));
    wire wr_stb    = byte_done && is_data && (kind == K_SELF) && !rw;

    // ====================================================================
    // decode of a completed byte
    always_comb begin
        next_ack  = 1'b1;
        next_ill  = 1'b0;
        next_kind = kind;
        is_data   = (byte_idx == IDX_DATA) ||
                    ((byte_idx == IDX_SECOND) && !two_byte_addressing_select_i);
        if (byte_idx == IDX_ADDR) begin
            next_kind = K_NONE;
            // R08 broadcast use checked
            if (bcast_seen || (rx_sh[7:1] == BCAST_ADDR && rx_sh[0])) begin
                next_ack = 1'b0;
                next_ill = 1'b1;
            end else if (rx_sh[7:1] == BCAST_ADDR) begin
                next_kind = K_BCAST;
            end else if (rx_sh[3:1] != host_side_module_id_i) begin
                next_ack = 1'b0;
            end else if (rx_sh[7:4] == HUB_LID) begin
                next_kind = K_SELF;
                // R07 refused read restart
                next_ack  = !(rx_sh[0] && refuse_read_i);
            end else begin
                next_kind = K_LOCAL;
            end
        end
        // R01 array or registers
        if (kind == K_LOCAL) begin
            next_tx = local_rd_data_i;
        end else if (tgt_nvm) begin
            next_tx = nvm_mem[ptr];
        end else begin
            next_tx = reg_mem[ptr[REG_AW-1:0]];
        end
    end

    // ====================================================================
    // packet engine
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st         <= ST_IDLE;
            kind       <= K_NONE;
            bit_cnt    <= 4'h0;
            byte_idx   <= IDX_ADDR;
            rx_sh      <= 8'h00;
            tx_sh      <= 8'h00;
            rw         <= 1'b0;
            tgt_nvm    <= 1'b0;
            bcast_seen <= 1'b0;
            sda_oe     <= 1'b1;
            ptr        <= '0;
        end else if (start_det) begin
            st       <= ST_RECV;
            bit_cnt  <= 4'h0;
            byte_idx <= IDX_ADDR;
            sda_oe   <= 1'b1;
        end else if (stop_det) begin
            st         <= ST_IDLE;
            kind       <= K_NONE;
            sda_oe     <= 1'b1;
            bcast_seen <= 1'b0;
            // R09 stop reload
            // R10 control pins
            // R12 register space only
            // R11 address-free read
            if (default_pointer_enable_i) begin
                ptr     <= {3'h0, hub_def_ptr(default_pointer_start_select_i)};
                tgt_nvm <= 1'b0;
            end
        end else begin
            case (st)
                ST_RECV: begin
                    if (scl_rise) begin
                        rx_sh   <= {rx_sh[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        st     <= ST_ACK;
                        sda_oe <= ~next_ack;
                        kind   <= next_kind;
                        if (byte_idx != IDX_DATA) begin
                            byte_idx <= byte_idx + 2'h1;
                        end
                        if (byte_idx == IDX_ADDR) begin
                            rw         <= rx_sh[0];
                            bcast_seen <= (next_kind == K_BCAST);
                        end
                        if (kind == K_SELF && byte_idx == IDX_FIRST) begin
                            // R03 select, block bit 0, offset
                            // R02 registers take plain address
                            tgt_nvm <= rx_sh[7];
                            // R19 page pointer
                            // R18 mode select
                            ptr <= {(rx_sh[7] && !two_byte_addressing_select_i) ? page_pointer_field_i : 3'h0,
                                    rx_sh[6:0]};
                        end
                        if (kind == K_SELF && byte_idx == IDX_SECOND && two_byte_addressing_select_i) begin
                            // R05 block bits 3..1
                            // R06 bit 4 dropped
                            ptr[NVM_AW-1:REG_AW] <= tgt_nvm ? rx_sh[2:0] : 3'h0;
                        end
                        // R21 write advance
                        if (wr_stb) begin
                            ptr <= ptr + 10'h001;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !load_now) begin
                        sda_oe  <= 1'b1;
                        bit_cnt <= 4'h0;
                        st      <= sda_oe ? ST_IDLE : ST_RECV;
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            sda_oe <= 1'b1;
                            st     <= ST_RACK;
                        end else begin
                            sda_oe  <= tx_sh[7];
                            tx_sh   <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // R20 host not-acknowledge ends read
                    if (scl_rise && sda_f) begin
                        st <= ST_IDLE;
                    end
                end
                default: st <= ST_IDLE;
            endcase
            // R04 sequential read data
            if (load_now) begin
                sda_oe  <= next_tx[7];
                tx_sh   <= {next_tx[6:0], 1'b0};
                bit_cnt <= 4'h1;
                st      <= ST_SEND;
                // R21 read advance
                if (kind == K_SELF) begin
                    ptr <= ptr + 10'h001;
                end
            end
        end
    end

    // ====================================================================
    // array and register writes; no write-cycle time is modelled
    always_ff @(posedge ref_clk_i) begin
        if (wr_stb && tgt_nvm) begin
            nvm_mem[ptr] <= rx_sh;
        end
        if (wr_stb && !tgt_nvm) begin
            reg_mem[ptr[REG_AW-1:0]] <= rx_sh;
        end
    end

    // ====================================================================
    // local bus side and pins
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            local_addr_o       <= 7'h00;
            local_rw_o         <= 1'b0;
            local_start_o      <= 1'b0;
            local_data_o       <= 8'h00;
            local_data_valid_o <= 1'b0;
            local_rd_req_o     <= 1'b0;
            local_stop_o       <= 1'b0;
            illegal_op_o       <= 1'b0;
            link.dev_sda_o     <= 1'b0;
            link.dev_sda_oe    <= 1'b1;
        end else begin
            local_start_o      <= byte_done && (byte_idx == IDX_ADDR) && (next_kind == K_LOCAL);
            // R17 code kept, id substituted
            if (byte_done && (byte_idx == IDX_ADDR)) begin
                local_addr_o <= {rx_sh[7:4], LOCAL_ID};
                local_rw_o   <= rx_sh[0];
            end
            // R14 plain data forwarding
            // R15 check bytes pass as data
            local_data_valid_o <= byte_done && (byte_idx != IDX_ADDR) && (kind == K_LOCAL);
            if (byte_done) begin
                local_data_o <= rx_sh;
            end
            local_rd_req_o     <= load_now && (kind == K_LOCAL);
            local_stop_o       <= stop_det && (kind == K_LOCAL);
            illegal_op_o       <= byte_done && (byte_idx == IDX_ADDR) && next_ill;
            link.dev_sda_o     <= 1'b0;
            link.dev_sda_oe    <= sda_oe;
        end
    end

endmodule // hub_target
